/* core/acp_pkg.sv */
// Operation
// - Two-wire, four-wire, self-boot; three latch pulls switch.
// - Boot pin high at start selects self-boot.
// - Memories and registers readable and writable; shadow set and trigger 0x810-0x81a write-only.
// - Single-word and burst access everywhere.
// - Byte zero: seven-bit chip address, direction.
// - Bytes one and two form subaddress.
// - Bytes from the fourth on are payload.
// - Subaddress decode gives payload word length.
// - Shadow set moves in within one frame.
// - Shadow transfer arbitrated against port access.
// - Two-wire side is slave only, never initiates.
// - Answers eight address byte values 0x68-0x6f.
// - Two address bits come from select pins.
// - Address lsb one reads, zero writes.
// - Start is sda fall, scl high; msb first.
// - Idle watches for start and own address.
// - Acknowledge by pulling sda low, ninth clock.
// - Burst advances subaddress at each word boundary; reads hold at 0x81f.
// - Invalid subaddress: no acknowledge, back to idle.
// - Stray stop returns to idle; stray start opens a new address byte.
package acp_pkg;
  localparam int          ACP_AW      = 12;
  localparam int          ACP_DW      = 40;
  localparam logic [4:0]  DEV_ADDR_HI = 5'h0d;
  localparam logic [1:0]  LATCH_LAST  = 2'h2;
  localparam logic [1:0]  STRAP_WAIT  = 2'h3;
  localparam logic [3:0]  BIT_LAST    = 4'h8;
  localparam logic [11:0] SUB_PROG    = 12'h400;
  localparam logic [11:0] SUB_REG     = 12'h800;
  localparam logic [11:0] SUB_SH_DAT  = 12'h810;
  localparam logic [11:0] SUB_SH_GO   = 12'h81a;
  localparam logic [11:0] SUB_MAX     = 12'h81f;
  localparam logic [2:0]  LEN_PARAM   = 3'h4;
  localparam logic [2:0]  LEN_PROG    = 3'h5;
  localparam logic [2:0]  LEN_REG     = 3'h2;
  localparam logic [2:0]  LEN_SH      = 3'h5;
  localparam logic [3:0]  SH_WORDS    = 4'h5;

  typedef enum logic [2:0] {
    MODE_TWO  = 3'b001,
    MODE_FOUR = 3'b010,
    MODE_BOOT = 3'b100
  } acp_mode_t;

  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_RX    = 6'b000010,
    ST_RXACK = 6'b000100,
    ST_TX    = 6'b001000,
    ST_TXACK = 6'b010000,
    ST_WAIT  = 6'b100000
  } acp_state_t;

  // Payload bytes per word at a subaddress; zero marks an invalid location.
  function automatic logic [2:0] acp_word_len(input logic [11:0] sub);
    if (sub < SUB_PROG) return LEN_PARAM;
    if (sub < SUB_REG) return LEN_PROG;
    if (sub >= SUB_SH_DAT && sub < SUB_SH_GO) return LEN_SH;
    if (sub <= SUB_MAX) return LEN_REG;
    return 3'h0;
  endfunction : acp_word_len

  // Moves the top payload byte of a word to bits 39:32.
  function automatic logic [39:0] acp_align(input logic [39:0] w, input logic [2:0] len);
    case (len)
      3'h1:    return {w[7:0], 32'h0};
      3'h2:    return {w[15:0], 24'h0};
      3'h3:    return {w[23:0], 16'h0};
      3'h4:    return {w[31:0], 8'h0};
      default: return w;
    endcase
  endfunction : acp_align
endpackage : acp_pkg

/* core/acp_mem_if.sv */
interface acp_mem_if;
  import acp_pkg::*;
  logic              req;
  logic              we;
  logic [ACP_AW-1:0] addr;
  logic [ACP_DW-1:0] wdata;
  logic [ACP_DW-1:0] rdata;
  modport master (output req, output we, output addr, output wdata, input rdata);
  modport slave (input req, input we, input addr, input wdata, output rdata);
endinterface : acp_mem_if

/* core/acp_mem.sv */
module acp_mem import acp_pkg::*; #(
  parameter int AW = ACP_AW,
  parameter int DW = ACP_DW
) (
  // Clock, reset and enable.
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // Access port.
  acp_mem_if.slave m
);
  logic [DW-1:0] mem_q [2**AW];
  logic [DW-1:0] rd_q;

  always_ff @(posedge mclk) begin
    if (ce && m.req && m.we) begin
      mem_q[m.addr] <= m.wdata;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rd_q <= '0;
    end else if (ce && m.req && !m.we) begin
      // Writes leave the read register alone, so a shadow write cannot spoil a pending read.
      rd_q <= mem_q[m.addr];
    end
  end

  assign m.rdata = rd_q;
endmodule : acp_mem

/* core/acp_shadow.sv */
module acp_shadow import acp_pkg::*; (
  // Clock, reset and enable.
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        ce,
  // Loading from the control port.
  input wire logic        ld,
  input wire logic [3:0]  ld_slot,
  input wire logic [39:0] ld_data,
  input wire logic        go,
  // Frame timing and arbitration.
  input wire logic        frame,
  input wire logic        gnt,
  acp_mem_if.master       m
);
  typedef struct packed {
    logic [4:0][39:0] dat;
    logic [4:0][11:0] adr;
    logic             pend;
    logic             act;
    logic [3:0]       idx;
  } acp_sh_st_t;

  acp_sh_st_t q;
  acp_sh_st_t d;

  always_comb begin
    d = q;
    if (ld && !q.act) begin
      if (ld_slot < SH_WORDS) begin
        d.dat[ld_slot[2:0]] = ld_data;
      end else begin
        d.adr[3'(ld_slot - SH_WORDS)] = ld_data[11:0];
      end
    end
    if (q.act && gnt) begin
      d.idx = q.idx + 4'h1;
      if (q.idx == SH_WORDS - 4'h1) begin
        d.act = 1'b0;
      end
    end
    if (q.pend && frame && !q.act) begin
      d.act  = 1'b1;
      d.idx  = 4'h0;
      d.pend = 1'b0;
    end
    // A request landing with the frame strobe stays pending.
    if (go) begin
      d.pend = 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  assign m.req   = q.act;
  assign m.we    = 1'b1;
  assign m.addr  = q.adr[q.idx[2:0]];
  assign m.wdata = q.dat[q.idx[2:0]];

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  a_sh_frame_start:
    assert property (ce && q.pend && frame && !q.act |=> q.act && q.idx == 4'h0)
    else $error("shadow set not started on frame strobe");
  a_sh_finish:
    assert property ($rose(q.act) |-> ##[1:200] !q.act)
    else $error("shadow transfer did not finish in time");
  a_sh_yield:
    assert property (q.act && !(gnt && ce) |=> $stable(q.idx))
    else $error("shadow advanced without the memory grant");
endmodule : acp_shadow

/* core/acp_ctrl_port.sv */
module acp_ctrl_port import acp_pkg::*; (
  // Clock, reset and enable.
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic       ce,
  // Two-wire bus pins.
  input wire logic       scl_i,
  input wire logic       sda_i,
  output logic           sda_o,
  output logic           sda_oe,
  // Straps and mode pins.
  input wire logic       boot_sel,
  input wire logic       serial_latch_or_write_protect,
  input wire logic       slave_id_pin_low,
  input wire logic       slave_id_pin_high,
  // Core timing and status.
  input wire logic       frame_tick,
  output acp_mode_t      ctrl_mode
);
  typedef struct packed {
    acp_mode_t        mode;
    logic             strap_done;
    logic [1:0]       strap_cnt;
    logic [2:0]       scl_s;
    logic [2:0]       sda_s;
    logic [2:0]       lat_s;
    logic [2:0]       boot_s;
    logic [2:0][1:0]  id_s;
    logic             scl_f;
    logic             sda_f;
    logic             lat_f;
    logic [1:0]       lat_cnt;
    acp_state_t       st;
    logic [3:0]       cnt;
    logic [7:0]       sh;
    logic             rw;
    logic             ack;
    logic             reload;
    logic [1:0]       idx;
    logic [11:0]      sub;
    logic [2:0]       bc;
    logic [39:0]      acc;
    logic             oe;
    logic             sdo;
    logic             mreq;
    logic             mwe;
    logic [11:0]      maddr;
    logic [39:0]      mdat;
    logic             shld;
    logic             shgo;
  } acp_top_st_t;

  localparam acp_top_st_t TOP_RST = '{mode: MODE_TWO, st: ST_IDLE, scl_s: 3'h7, sda_s: 3'h7,
                                      lat_s: 3'h7, scl_f: 1'b1, sda_f: 1'b1, lat_f: 1'b1,
                                      default: '0};

  acp_top_st_t q;
  acp_top_st_t d;
  logic        scl_n;
  logic        sda_n;
  logic        lat_n;
  logic        rise;
  logic        fall;
  logic        start;
  logic        stop;
  logic        i2c_on;
  logic        ok;
  logic [2:0]  len;
  logic [11:0] sub_n;
  logic [39:0] tx_w;

  acp_mem_if mem_bus ();
  acp_mem_if sh_bus ();

  ////////////////////////////////////////////////////////////////////////////
  // Memory, shadow buffer and arbitration; the port always wins.

  acp_mem u_mem (
    .mclk (mclk),
    .rst  (rst),
    .ce   (ce),
    .m    (mem_bus.slave)
  );

  acp_shadow u_shadow (
    .mclk    (mclk),
    .rst     (rst),
    .ce      (ce),
    .ld      (q.shld),
    .ld_slot (4'(q.maddr - SUB_SH_DAT)),
    .ld_data (q.mdat),
    .go      (q.shgo),
    .frame   (frame_tick),
    .gnt     (!q.mreq),
    .m       (sh_bus.master)
  );

  assign mem_bus.req   = q.mreq | sh_bus.req;
  assign mem_bus.we    = q.mreq ? q.mwe : sh_bus.we;
  assign mem_bus.addr  = q.mreq ? q.maddr : sh_bus.addr;
  assign mem_bus.wdata = q.mreq ? q.mdat : sh_bus.wdata;
  assign sh_bus.rdata  = mem_bus.rdata;

  ////////////////////////////////////////////////////////////////////////////
  // Pin filtering, mode selection and the two-wire slave.

  assign scl_n  = (q.scl_s[1] == q.scl_s[2]) ? q.scl_s[2] : q.scl_f;
  assign sda_n  = (q.sda_s[1] == q.sda_s[2]) ? q.sda_s[2] : q.sda_f;
  assign lat_n  = (q.lat_s[1] == q.lat_s[2]) ? q.lat_s[2] : q.lat_f;
  assign rise   = scl_n & ~q.scl_f;
  assign fall   = ~scl_n & q.scl_f;
  assign start  = q.scl_f & scl_n & q.sda_f & ~sda_n;
  assign stop   = q.scl_f & scl_n & ~q.sda_f & sda_n;
  // The slave steps aside in the very cycle that the third latch pull switches modes, so it cannot freeze mid-byte.
  assign i2c_on = q.strap_done && q.mode == MODE_TWO && !(q.lat_f && !lat_n && q.lat_cnt == LATCH_LAST);
  assign len    = acp_word_len(q.sub);
  assign tx_w   = q.reload ? acp_align(mem_bus.rdata, len) : q.acc;

  always_comb begin
    d        = q;
    d.mreq   = 1'b0;
    d.shld   = 1'b0;
    d.shgo   = 1'b0;
    d.sdo    = 1'b0;
    ok       = 1'b0;
    sub_n    = q.sub;
    d.scl_s  = {q.scl_s[1:0], scl_i};
    d.sda_s  = {q.sda_s[1:0], sda_i};
    d.lat_s  = {q.lat_s[1:0], serial_latch_or_write_protect};
    d.boot_s = {q.boot_s[1:0], boot_sel};
    d.id_s   = {q.id_s[1:0], slave_id_pin_high, slave_id_pin_low};
    d.scl_f  = scl_n;
    d.sda_f  = sda_n;
    d.lat_f  = lat_n;
    if (!q.strap_done) begin
      d.strap_cnt = q.strap_cnt + 2'h1;
      if (q.strap_cnt == STRAP_WAIT && q.boot_s[1] == q.boot_s[2]) begin
        d.strap_done = 1'b1;
        d.mode       = q.boot_s[2] ? MODE_BOOT : MODE_TWO;
      end
    end else if (q.mode == MODE_TWO && q.lat_f && !lat_n) begin
      d.lat_cnt = q.lat_cnt + 2'h1;
      if (q.lat_cnt == LATCH_LAST) begin
        d.mode = MODE_FOUR;
        d.st   = ST_IDLE;
        d.oe   = 1'b0;
      end
    end
    if (i2c_on) begin
      if (stop) begin
        d.st = ST_IDLE;
        d.oe = 1'b0;
      end else if (start) begin
        d.st  = ST_RX;
        d.cnt = 4'h0;
        d.idx = 2'h0;
        d.oe  = 1'b0;
      end else begin
        case (q.st)
          ST_RX: begin
            if (rise && q.cnt != BIT_LAST) begin
              d.sh  = {q.sh[6:0], sda_n};
              d.cnt = q.cnt + 4'h1;
            end else if (fall && q.cnt == BIT_LAST) begin
              case (q.idx)
                2'h0: begin
                  ok       = q.sh[7:1] == {DEV_ADDR_HI, q.id_s[2]};
                  d.rw     = q.sh[0];
                  d.bc     = 3'h0;
                  d.reload = 1'b1;
                  d.mreq   = ok;
                  d.mwe    = 1'b0;
                  d.maddr  = q.sub;
                end
                2'h1: begin
                  sub_n = {q.sh[3:0], q.sub[7:0]};
                  ok    = 1'b1;
                end
                2'h2: begin
                  sub_n = {q.sub[11:8], q.sh};
                  ok    = acp_word_len(sub_n) != 3'h0;
                  d.bc  = 3'h0;
                end
                default: begin
                  ok    = len != 3'h0;
                  d.acc = {q.acc[31:0], q.sh};
                  if (ok && q.bc == len - 3'h1) begin
                    d.bc    = 3'h0;
                    sub_n   = q.sub + 12'h1;
                    d.maddr = q.sub;
                    d.mdat  = {q.acc[31:0], q.sh};
                    if (q.sub >= SUB_SH_DAT && q.sub < SUB_SH_GO) begin
                      d.shld = 1'b1;
                    end else if (q.sub == SUB_SH_GO) begin
                      d.shgo = 1'b1;
                    end else begin
                      d.mreq = 1'b1;
                      d.mwe  = 1'b1;
                    end
                  end else begin
                    d.bc = q.bc + 3'h1;
                  end
                end
              endcase
              d.sub = sub_n;
              if (q.idx != 2'h3) begin
                d.idx = q.idx + 2'h1;
              end
              d.st = ok ? ST_RXACK : (q.idx == 2'h0 ? ST_WAIT : ST_IDLE);
              d.oe = ok;
            end
          end
          ST_RXACK: begin
            if (fall) begin
              d.cnt = 4'h0;
              if (q.rw) begin
                d.acc    = {tx_w[31:0], 8'h0};
                d.sh     = {tx_w[38:32], 1'b1};
                d.oe     = ~tx_w[39];
                d.reload = 1'b0;
                d.st     = ST_TX;
              end else begin
                d.oe = 1'b0;
                d.st = ST_RX;
              end
            end
          end
          ST_TX: begin
            if (rise) begin
              d.cnt = q.cnt + 4'h1;
            end else if (fall) begin
              if (q.cnt == BIT_LAST) begin
                d.oe = 1'b0;
                d.st = ST_TXACK;
              end else begin
                d.oe = ~q.sh[7];
                d.sh = {q.sh[6:0], 1'b1};
              end
            end
          end
          ST_TXACK: begin
            if (rise) begin
              if (sda_n) begin
                d.st = ST_IDLE;
              end else begin
                d.ack = 1'b1;
                if (q.bc == len - 3'h1) begin
                  d.bc     = 3'h0;
                  sub_n    = (q.sub == SUB_MAX) ? q.sub : q.sub + 12'h1;
                  d.sub    = sub_n;
                  d.reload = 1'b1;
                  d.mreq   = 1'b1;
                  d.mwe    = 1'b0;
                  d.maddr  = sub_n;
                end else begin
                  d.bc = q.bc + 3'h1;
                end
              end
            end else if (fall && q.ack) begin
              d.ack    = 1'b0;
              d.cnt    = 4'h0;
              d.acc    = {tx_w[31:0], 8'h0};
              d.sh     = {tx_w[38:32], 1'b1};
              d.oe     = ~tx_w[39];
              d.reload = 1'b0;
              d.st     = ST_TX;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      q <= TOP_RST;
    end else if (ce) begin
      q <= d;
    end
  end

  assign sda_o     = q.sdo;
  assign sda_oe    = q.oe;
  assign ctrl_mode = q.mode;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  a_idle_quiet:
    assert property (q.st inside {ST_IDLE, ST_WAIT} |-> !sda_oe)
    else $error("sda driven while idle");
  a_start_addr:
    assert property (ce && i2c_on && start && !stop |=> q.st == ST_RX && q.idx == 2'h0 && q.cnt == 4'h0)
    else $error("start did not open an address byte");
  a_stop_idle:
    assert property (ce && i2c_on && stop |=> q.st == ST_IDLE && !sda_oe)
    else $error("stop did not return to idle");
  a_addr_ack:
    assert property (ce && i2c_on && !start && !stop && q.st == ST_RX && fall && q.cnt == BIT_LAST
                     && q.idx == 2'h0 && q.sh[7:1] == {DEV_ADDR_HI, q.id_s[2]}
                     |=> sda_oe && q.rw == $past(q.sh[0]))
    else $error("own address not acknowledged");
  a_addr_miss:
    assert property (ce && i2c_on && !start && !stop && q.st == ST_RX && fall && q.cnt == BIT_LAST
                     && q.idx == 2'h0 && q.sh[7:1] != {DEV_ADDR_HI, q.id_s[2]}
                     |=> q.st == ST_WAIT && !sda_oe)
    else $error("foreign address acknowledged");
  a_bad_sub:
    assert property (ce && i2c_on && !start && !stop && q.st == ST_RX && fall && q.cnt == BIT_LAST
                     && q.idx == 2'h2 && acp_word_len({q.sub[11:8], q.sh}) == 3'h0
                     |=> q.st == ST_IDLE && !sda_oe)
    else $error("invalid subaddress acknowledged");
  a_burst_step:
    assert property (q.mreq && q.mwe |-> q.sub == q.maddr + 12'h1 && q.bc == 3'h0)
    else $error("subaddress not advanced at word end");
  a_mode_four:
    assert property (ce && q.strap_done && q.mode == MODE_TWO && q.lat_cnt == LATCH_LAST && q.lat_f && !lat_n
                     |=> ctrl_mode == MODE_FOUR && q.st == ST_IDLE && !sda_oe)
    else $error("third latch pull did not switch mode");
endmodule : acp_ctrl_port

/* test/acp_i2c_master.sv */
module acp_i2c_master (
  // Clock.
  input  wire logic mclk,
  // Two-wire bus, seen and driven.
  input  wire logic sda_in,
  output logic      scl,
  output logic      sda_m
);
  timeunit 1ns;
  timeprecision 1ps;

  localparam int Q = 5;

  // The bus idles high and the clock stands still between frames.
  initial begin
    scl   = 1'h1;
    sda_m = 1'h1;
  end

  task automatic tk(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tk

  ////////////////////////////////////////////////////////////////////////////
  // One clock pulse; data is set while the clock is low and sampled late in the high phase.
  task automatic bit_io(input logic b, output logic s);
    sda_m = b;
    tk(Q);
    scl = 1'h1;
    tk(2 * Q);
    s   = sda_in;
    scl = 1'h0;
    tk(Q);
  endtask : bit_io

  // Also serves as a repeated start when entered with the clock low.
  task automatic start_c;
    sda_m = 1'h1;
    tk(Q);
    scl = 1'h1;
    tk(Q);
    sda_m = 1'h0;
    tk(Q);
    scl = 1'h0;
    tk(Q);
  endtask : start_c

  task automatic stop_c;
    sda_m = 1'h0;
    tk(Q);
    scl = 1'h1;
    tk(Q);
    sda_m = 1'h1;
    tk(2 * Q);
  endtask : stop_c

  task automatic send(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], s);
    end
    bit_io(1'h1, s);
    ack = ~s;
  endtask : send

  task automatic recv(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'h1, s);
      b[i] = s;
    end
    bit_io(last, s);
  endtask : recv
endmodule : acp_i2c_master

/* test/tb.sv */
module tb import acp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [1:0]  id;
    logic [11:0] sub;
    logic [2:0]  n;
    logic [39:0] d;
  } acp_row_t;

  logic      mclk, rst, ce, scl, sda_m, sda, sda_o, sda_oe, boot_sel;
  logic      serial_latch_or_write_protect, slave_id_pin_low, slave_id_pin_high, frame_tick;
  acp_mode_t ctrl_mode;
  int        n_errors, n_checks;
  logic      a;
  logic [39:0] d;
  acp_row_t  rows [4] = '{'{2'h0, 12'h800, 3'h2, 40'h1234}, '{2'h1, 12'h000, 3'h4, 40'hdeadbeef},
                         '{2'h2, 12'h400, 3'h5, 40'h0102030405}, '{2'h3, 12'h81f, 3'h2, 40'ha55a}};

  // Pull-up on the data line: low when either side pulls it.
  assign sda = sda_m & ~sda_oe;

  acp_ctrl_port uut (.mclk(mclk), .rst(rst), .ce(ce), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .boot_sel(boot_sel), .serial_latch_or_write_protect(serial_latch_or_write_protect),
    .slave_id_pin_low(slave_id_pin_low), .slave_id_pin_high(slave_id_pin_high),
    .frame_tick(frame_tick), .ctrl_mode(ctrl_mode));
  acp_i2c_master mst (.mclk(mclk), .sda_in(sda), .scl(scl), .sda_m(sda_m));

  initial begin
    mclk = 1'h0;
    forever #12.5 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic tk(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tk

  task automatic chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic tally_and_finish;
    $display("Checks made %0d, mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish

  task automatic addr(input logic rw, output logic ack);
    mst.send({DEV_ADDR_HI, slave_id_pin_high, slave_id_pin_low, rw}, ack);
  endtask : addr

  // Start, write address, subaddress; returns the acknowledge of the low subaddress byte.
  task automatic sub_w(input logic [11:0] s, output logic ack);
    mst.start_c();
    addr(1'h0, ack);
    chk("addr ack", 40'(ack), 40'h1);
    mst.send({4'h0, s[11:8]}, ack);
    chk("sub high ack", 40'(ack), 40'h1);
    mst.send(s[7:0], ack);
  endtask : sub_w

  task automatic wr(input logic [39:0] v, input int n);
    logic k;
    for (int i = n - 1; i >= 0; i--) begin
      mst.send(v[8*i+:8], k);
      chk("data ack", 40'(k), 40'h1);
    end
  endtask : wr

  task automatic rd(input int n, output logic [39:0] v);
    logic       k;
    logic [7:0] b;
    mst.start_c();
    addr(1'h1, k);
    chk("read addr ack", 40'(k), 40'h1);
    v = 40'h0;
    for (int i = n - 1; i >= 0; i--) begin
      mst.recv(i == 0, b);
      v[8*i+:8] = b;
    end
    mst.stop_c();
  endtask : rd

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (90000) @(posedge mclk);
    n_errors++;
    tally_and_finish();
  end

  initial begin
    rst = 1'h1;
    ce = 1'h1;
    boot_sel = 1'h0;
    serial_latch_or_write_protect = 1'h1;
    slave_id_pin_low = 1'h0;
    slave_id_pin_high = 1'h0;
    frame_tick = 1'h0;
    n_errors = 0;
    n_checks = 0;
    tk(4);
    chk("reset mode", 40'(ctrl_mode), 40'(MODE_TWO));
    chk("reset oe", 40'(sda_oe), 40'h0);
    rst = 1'h0;
    tk(12);
    chk("two-wire mode", 40'(ctrl_mode), 40'(MODE_TWO));
    foreach (rows[i]) begin
      {slave_id_pin_high, slave_id_pin_low} = rows[i].id;
      tk(4);
      sub_w(rows[i].sub, a);
      chk("sub low ack", 40'(a), 40'h1);
      wr(rows[i].d, int'(rows[i].n));
      mst.stop_c();
      sub_w(rows[i].sub, a);
      rd(int'(rows[i].n), d);
      chk("row data", d, rows[i].d);
    end
    {slave_id_pin_high, slave_id_pin_low} = 2'h0;
    tk(4);
    mst.start_c();
    mst.send({DEV_ADDR_HI, 2'h3, 1'h0}, a);
    chk("foreign addr nack", 40'(a), 40'h0);
    mst.send(8'h08, a);
    chk("stays idle", 40'(a), 40'h0);
    mst.stop_c();
    sub_w(12'h801, a);
    wr(40'h11112222, 4);
    mst.stop_c();
    sub_w(12'h802, a);
    rd(2, d);
    chk("burst write step", d, 40'h2222);
    sub_w(12'h801, a);
    rd(4, d);
    chk("burst read", d, 40'h11112222);
    sub_w(12'h81f, a);
    wr(40'hbeef, 2);
    mst.send(8'h99, a);
    chk("write past end nack", 40'(a), 40'h0);
    mst.stop_c();
    sub_w(12'h81f, a);
    rd(4, d);
    chk("read clamps", d, 40'hbeefbeef);
    sub_w(12'h820, a);
    chk("bad sub nack", 40'(a), 40'h0);
    mst.send(8'h55, a);
    chk("bad sub idle", 40'(a), 40'h0);
    mst.stop_c();
    sub_w(12'h800, a);
    mst.send(8'h77, a);
    mst.stop_c();
    mst.start_c();
    addr(1'h0, a);
    mst.send(8'h08, a);
    sub_w(12'h800, a);
    rd(2, d);
    chk("stray stop and start", d, 40'h1234);
    sub_w(12'h120, a);
    for (int k = 0; k < 5; k++) wr(40'h0, 4);
    mst.stop_c();
    sub_w(SUB_SH_DAT, a);
    for (int k = 0; k < 5; k++) wr(40'h0a0b0c0d00 + 40'(k), 5);
    for (int k = 0; k < 5; k++) wr(40'h120 + 40'(k), 5);
    mst.stop_c();
    sub_w(SUB_SH_GO, a);
    wr(40'h1, 2);
    mst.stop_c();
    sub_w(12'h120, a);
    rd(4, d);
    chk("held until frame", d, 40'h0);
    frame_tick = 1'h1;
    tk(1);
    frame_tick = 1'h0;
    tk(20);
    for (int k = 0; k < 5; k++) begin
      sub_w(12'h120 + 12'(k), a);
      rd(4, d);
      chk("shadow word", d, 40'h0b0c0d00 + 40'(k));
    end
    // A pull while the clock enable is low must not count.
    ce = 1'h0;
    serial_latch_or_write_protect = 1'h0;
    tk(8);
    serial_latch_or_write_protect = 1'h1;
    tk(8);
    ce = 1'h1;
    tk(8);
    chk("frozen pull ignored", 40'(ctrl_mode), 40'(MODE_TWO));
    for (int k = 0; k < 3; k++) begin
      chk("mode before third pull", 40'(ctrl_mode), 40'(MODE_TWO));
      serial_latch_or_write_protect = 1'h0;
      tk(8);
      serial_latch_or_write_protect = 1'h1;
      tk(8);
    end
    chk("four-wire mode", 40'(ctrl_mode), 40'(MODE_FOUR));
    mst.start_c();
    addr(1'h0, a);
    chk("pins ignored", 40'(a), 40'h0);
    mst.stop_c();
    chk("sda_o low", 40'(sda_o), 40'h0);
    boot_sel = 1'h1;
    rst = 1'h1;
    tk(2);
    rst = 1'h0;
    tk(12);
    chk("self-boot mode", 40'(ctrl_mode), 40'(MODE_BOOT));
    tally_and_finish();
  end
endmodule : tb
